/* File: rse_pkg.sv */
package rse_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	// power-up self test window before replies are served
	localparam int unsigned STARTUP_US = 1000;
	localparam int unsigned STARTUP_CYC = (CLK_HZ / 1_000_000) * STARTUP_US;
	// dwell of each led during the lamp test
	localparam int unsigned LAMP_STEP_MS = 250;
	localparam int unsigned LAMP_STEP_CYC = (CLK_HZ / 1000) * LAMP_STEP_MS;
	// switches taken once the two-stage synchroniser has settled
	localparam int unsigned DIP_CAPTURE_CYC = 4;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] OFS_LOOP_DLY = 12'h000;
	localparam logic [11:0] OFS_DEV_STAT = 12'h004;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [7:0] LOOP_DLY_RST = 8'h0a;
	localparam logic [7:0] LOOP_DLY_MIN = 8'h01;
	localparam logic [7:0] LOOP_DLY_MAX = 8'h64;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// first status byte layout
	// ----------------------------------------
	localparam int unsigned B0_FORM = 7;
	localparam int unsigned B0_PARITY = 6;
	localparam int unsigned B0_OVERRUN = 5;
	localparam int unsigned B0_FRAMING = 4;
	localparam int unsigned B0_CHECKSUM = 3;
	localparam int unsigned B0_RSVD = 2;
	localparam int unsigned B0_BUF_OVF = 1;
	localparam int unsigned B0_UNDEF = 0;
	localparam logic [6:0] RESP_SUCCESS = 7'h00;
	localparam logic [6:0] RESP_WARN_A = 7'h08;
	localparam logic [6:0] RESP_WARN_B = 7'h1f;

	// ----------------------------------------
	// interrupt bits and switch fields
	// ----------------------------------------
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_RX_FAULT = 0;
	localparam int unsigned IRQ_REPLY = 1;
	localparam int unsigned IRQ_CMD_ERR = 2;
	localparam int unsigned IRQ_START_FLT = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam int unsigned DIP_LAMP = 0;
	localparam int unsigned DIP_ADDR_LSB = 1;
	localparam int unsigned DIP_ADDR_W = 4;
	localparam int unsigned DIP_BAUD_LSB = 5;
	localparam int unsigned DIP_BAUD_W = 3;

	// led display selected by the start-up result
	typedef enum logic [1:0] {LED_RUN, LED_RED_ONLY, LED_RED_GRN, LED_ALL} rse_led_t;

	// warning codes let command processing go on
	function automatic logic rse_is_warning(input logic [6:0] code);
		rse_is_warning = (code == RESP_WARN_A) || (code == RESP_WARN_B);
	endfunction

endpackage

/* File: rse_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module rse_sync import rse_pkg::*; #(
	parameter int unsigned W = 8
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r; // first stage, read only by the second
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// next values
	always_comb begin
		meta_nxt = async_i;
		sync_nxt = meta_r;
	end

	// registers
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else if (ce_i) begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;
endmodule

/* File: rse_lamp.sv */
`timescale 1ns/10ps
// led driver: fault patterns and the sequential lamp test
module rse_lamp import rse_pkg::*; #(
	parameter int unsigned STEP_CYC = LAMP_STEP_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic lamp_i,
	input wire rse_led_t code_i,
	output logic led_red_o,
	output logic led_green_o,
	output logic led_orange_o
);
	logic [31:0] cnt_r; // dwell counter of one lamp step
	logic [31:0] cnt_nxt;
	logic [1:0] phase_r; // 0 red, 1 green, 2 orange
	logic [1:0] phase_nxt;
	logic [2:0] led_r; // {orange, green, red}
	logic [2:0] led_nxt;

	// ----------------------------------------
	// next values
	// ----------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		phase_nxt = phase_r;
		led_nxt = 3'h2;
		if (lamp_i) begin
			if (cnt_r == STEP_CYC - 1) begin
				cnt_nxt = '0;
				phase_nxt = (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
			end else begin
				cnt_nxt = cnt_r + 32'h1;
			end
			led_nxt = 3'h1 << phase_r;
		end else begin
			unique case (code_i)
				LED_RUN: led_nxt = 3'h2;
				LED_RED_ONLY: led_nxt = 3'h1;
				LED_RED_GRN: led_nxt = 3'h3;
				LED_ALL: led_nxt = 3'h7;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cnt_r <= '0;
			phase_r <= 2'h0;
			led_r <= 3'h0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			led_r <= led_nxt;
		end
	end

	assign led_red_o = led_r[0];
	assign led_green_o = led_r[1];
	assign led_orange_o = led_r[2];

	AST_LAMP_ONE_HOT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && lamp_i |=> $onehot({led_orange_o, led_green_o, led_red_o}))
		else $error("lamp test lit other than one led");
	AST_RED_GRN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && !lamp_i && code_i == LED_RED_GRN |=> led_red_o && led_green_o && !led_orange_o)
		else $error("memory fault pattern wrong");
	AST_CPU_FAULT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && !lamp_i && code_i == LED_ALL |=> led_red_o && led_green_o && led_orange_o)
		else $error("processor fault pattern wrong");
endmodule

/* File: rse_top.sv */
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
// reply status byte former with start-up fault display and register slave
module rse_top import rse_pkg::*; #(
	parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
	parameter int unsigned LAMP_CYCLES = LAMP_STEP_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] dip_i,
	input wire logic msg_done_i,
	output logic msg_ready_o,
	input wire logic [3:0] msg_slave_i,
	input wire logic par_err_i,
	input wire logic ovr_err_i,
	input wire logic frm_err_i,
	input wire logic chk_err_i,
	input wire logic buf_ovf_i,
	output logic exec_req_o,
	output logic internal_sel_o,
	input wire logic exec_done_i,
	input wire logic [6:0] resp_code_i,
	input wire logic [7:0] dev_status_i,
	output logic [7:0] stat_byte_o,
	output logic stat_valid_o,
	output logic stat_first_o,
	input wire logic stat_ready_i,
	output logic hdr_done_o,
	input wire logic cpu_fault_i,
	input wire logic rom_fault_i,
	input wire logic ram_fault_i,
	output logic [DIP_ADDR_W-1:0] bus_addr_o,
	output logic [DIP_BAUD_W-1:0] baud_sel_o,
	output logic led_red_o,
	output logic led_green_o,
	output logic led_orange_o,
	output logic irq_o
);
	typedef enum {ST_IDLE, ST_EXEC, ST_BYTE0, ST_BYTE1} rse_state_t;

	// register index decode shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_LOOP_DLY: reg_sel = 3'h1;
			OFS_DEV_STAT: reg_sel = 3'h2;
			OFS_IRQ_STAT: reg_sel = 3'h3;
			OFS_IRQ_MASK: reg_sel = 3'h4;
			default: reg_sel = 3'h0;
		endcase
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] dip_s; // synchronised switches
	logic [31:0] boot_cnt_r, boot_cnt_nxt; // start-up window counter
	logic run_r, run_nxt; // start-up finished
	logic lamp_r, lamp_nxt; // lamp test chosen at power-up
	logic [DIP_ADDR_W-1:0] addr_r, addr_nxt;
	logic [DIP_BAUD_W-1:0] baud_r, baud_nxt;
	rse_led_t led_code_r, led_code_nxt;
	logic ev_start;
	rse_state_t st_r, st_nxt;
	logic [7:0] b0_r, b0_nxt; // first byte of the pending reply
	logic [7:0] b1_r, b1_nxt; // second byte of the pending reply
	logic [7:0] out_r, out_nxt; // byte on the status port
	logic exec_r, exec_nxt;
	logic sel_r, sel_nxt;
	logic hdr_r, hdr_nxt;
	logic msg_fire, rx_fault;
	logic ev_rx, ev_reply, ev_cmd;
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] loop_r, loop_nxt; // loop switch delay parameter
	logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
	logic do_write;

	// ----------------------------------------
	// switch inputs and led driver
	// ----------------------------------------
	rse_sync #(.W(8)) u_dip_sync (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.async_i(dip_i),
		.sync_o(dip_s)
	);

	rse_lamp #(.STEP_CYC(LAMP_CYCLES)) u_lamp (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.lamp_i(lamp_r),
		.code_i(led_code_r),
		.led_red_o(led_red_o),
		.led_green_o(led_green_o),
		.led_orange_o(led_orange_o)
	);

	// ----------------------------------------
	// start-up sequence
	// ----------------------------------------
	always_comb begin
		boot_cnt_nxt = boot_cnt_r;
		run_nxt = run_r;
		lamp_nxt = lamp_r;
		addr_nxt = addr_r;
		baud_nxt = baud_r;
		led_code_nxt = led_code_r;
		ev_start = 1'b0;
		if (!run_r) begin
			boot_cnt_nxt = boot_cnt_r + 32'h1;
			if (boot_cnt_r == DIP_CAPTURE_CYC) begin
				lamp_nxt = dip_s[DIP_LAMP];
				addr_nxt = dip_s[DIP_ADDR_LSB +: DIP_ADDR_W];
				baud_nxt = dip_s[DIP_BAUD_LSB +: DIP_BAUD_W];
			end
			// self test results judged at end of window
			if (boot_cnt_r == STARTUP_CYCLES - 1) begin
				run_nxt = 1'b1;
				if (cpu_fault_i) begin
					led_code_nxt = LED_ALL;
				end else if (rom_fault_i) begin
					led_code_nxt = LED_RED_ONLY;
				end else if (ram_fault_i || loop_r < LOOP_DLY_MIN || loop_r > LOOP_DLY_MAX) begin
					led_code_nxt = LED_RED_GRN;
				end
				ev_start = cpu_fault_i || rom_fault_i || ram_fault_i ||
					loop_r < LOOP_DLY_MIN || loop_r > LOOP_DLY_MAX;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			boot_cnt_r <= '0;
			run_r <= 1'b0;
			lamp_r <= 1'b0;
			addr_r <= '0;
			baud_r <= '0;
			led_code_r <= LED_RUN;
		end else if (ce_i) begin
			boot_cnt_r <= boot_cnt_nxt;
			run_r <= run_nxt;
			lamp_r <= lamp_nxt;
			addr_r <= addr_nxt;
			baud_r <= baud_nxt;
			led_code_r <= led_code_nxt;
		end
	end

	// ----------------------------------------
	// reply status byte former
	// ----------------------------------------
	// a faulted device refuses messages rather than answer with stale data
	assign msg_ready_o = (st_r == ST_IDLE) && run_r && (led_code_r == LED_RUN);
	assign msg_fire = msg_done_i && msg_ready_o;
	assign rx_fault = par_err_i || ovr_err_i || frm_err_i || chk_err_i || buf_ovf_i;

	always_comb begin
		st_nxt = st_r;
		b0_nxt = b0_r;
		b1_nxt = b1_r;
		out_nxt = out_r;
		exec_nxt = 1'b0;
		sel_nxt = sel_r;
		hdr_nxt = 1'b0;
		ev_rx = 1'b0;
		ev_reply = 1'b0;
		ev_cmd = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (msg_fire && rx_fault) begin
					b0_nxt = 8'h00;
					b0_nxt[B0_FORM] = 1'b1;
					b0_nxt[B0_PARITY] = par_err_i;
					b0_nxt[B0_OVERRUN] = ovr_err_i;
					b0_nxt[B0_FRAMING] = frm_err_i;
					b0_nxt[B0_CHECKSUM] = chk_err_i;
					b0_nxt[B0_RSVD] = 1'b0;
					b0_nxt[B0_BUF_OVF] = buf_ovf_i;
					b0_nxt[B0_UNDEF] = 1'b0;
					b1_nxt = 8'h00;
					out_nxt = b0_nxt;
					ev_rx = 1'b1;
					st_nxt = ST_BYTE0;
				end else if (msg_fire) begin
					exec_nxt = 1'b1;
					// address 0 is the internal group
					sel_nxt = (msg_slave_i == 4'h0);
					st_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (exec_done_i) begin
					b0_nxt = {1'b0, resp_code_i};
					b1_nxt = dev_status_i;
					out_nxt = b0_nxt;
					// warnings do not count as errors
					ev_cmd = (resp_code_i != RESP_SUCCESS) && !rse_is_warning(resp_code_i);
					st_nxt = ST_BYTE0;
				end
			end
			ST_BYTE0: begin
				if (stat_ready_i) begin
					out_nxt = b1_r;
					st_nxt = ST_BYTE1;
				end
			end
			ST_BYTE1: begin
				// payload may follow after two bytes
				if (stat_ready_i) begin
					hdr_nxt = 1'b1;
					ev_reply = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st_r <= ST_IDLE;
			b0_r <= 8'h00;
			b1_r <= 8'h00;
			out_r <= 8'h00;
			exec_r <= 1'b0;
			sel_r <= 1'b0;
			hdr_r <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			b0_r <= b0_nxt;
			b1_r <= b1_nxt;
			out_r <= out_nxt;
			exec_r <= exec_nxt;
			sel_r <= sel_nxt;
			hdr_r <= hdr_nxt;
		end
	end

	assign stat_byte_o = out_r;
	assign stat_valid_o = (st_r == ST_BYTE0) || (st_r == ST_BYTE1);
	assign stat_first_o = (st_r == ST_BYTE0);
	assign exec_req_o = exec_r;
	assign internal_sel_o = sel_r;
	assign hdr_done_o = hdr_r;
	assign bus_addr_o = addr_r;
	assign baud_sel_o = baud_r;

	// ----------------------------------------
	// register slave and interrupt
	// ----------------------------------------
	assign s_axi_awready_o = !aw_hold_r && !bvalid_r;
	assign s_axi_wready_o = !w_hold_r && !bvalid_r;
	assign s_axi_arready_o = !rvalid_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		loop_nxt = loop_r;
		imask_nxt = imask_r;
		ist_nxt = ist_r;
		// address and data are taken in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata_i;
			wstrb_nxt = s_axi_wstrb_i;
		end
		if (do_write) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (reg_sel(awaddr_r) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
			if (wstrb_r[0]) begin
				if (reg_sel(awaddr_r) == 3'h1) loop_nxt = wdata_r[7:0];
				if (reg_sel(awaddr_r) == 3'h4) imask_nxt = wdata_r[IRQ_W-1:0];
				if (reg_sel(awaddr_r) == 3'h3) ist_nxt = ist_r & ~wdata_r[IRQ_W-1:0];
			end
		end else if (bvalid_r && s_axi_bready_i) begin
			bvalid_nxt = 1'b0;
		end
		// events applied after the clear so a same-cycle event survives
		ist_nxt[IRQ_RX_FAULT] = ist_nxt[IRQ_RX_FAULT] | ev_rx;
		ist_nxt[IRQ_REPLY] = ist_nxt[IRQ_REPLY] | ev_reply;
		ist_nxt[IRQ_CMD_ERR] = ist_nxt[IRQ_CMD_ERR] | ev_cmd;
		ist_nxt[IRQ_START_FLT] = ist_nxt[IRQ_START_FLT] | ev_start;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (reg_sel(s_axi_araddr_i))
				3'h1: rdata_nxt = {24'h000000, loop_r};
				3'h2: rdata_nxt = {5'h00, run_r, led_code_r, lamp_r, baud_r, addr_r, b1_r, b0_r};
				3'h3: rdata_nxt = {28'h0000000, ist_r};
				3'h4: rdata_nxt = {28'h0000000, imask_r};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h00000000;
			loop_r <= LOOP_DLY_RST;
			imask_r <= IRQ_MASK_RST;
			ist_r <= '0;
		end else if (ce_i) begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			loop_r <= loop_nxt;
			imask_r <= imask_nxt;
			ist_r <= ist_nxt;
		end
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdata_r;
	assign irq_o = |(ist_r & imask_r);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_ERR_FORM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && msg_fire && rx_fault |=> stat_valid_o && stat_first_o &&
		stat_byte_o == {1'b1, $past(par_err_i), $past(ovr_err_i), $past(frm_err_i),
		$past(chk_err_i), 1'b0, $past(buf_ovf_i), 1'b0})
		else $error("error form first byte wrong");
	AST_NO_EXEC: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && msg_fire && rx_fault |=> !exec_req_o ##1 !exec_req_o)
		else $error("faulty message was executed");
	AST_ERR_BYTE1_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		stat_valid_o && !stat_first_o && b0_r[B0_FORM] |-> stat_byte_o == 8'h00)
		else $error("second byte not zero in error form");
	AST_UNDEF_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		stat_first_o && stat_byte_o[B0_FORM] |-> !stat_byte_o[B0_UNDEF] && !stat_byte_o[B0_RSVD])
		else $error("undefined or reserved bit set");
	AST_RESP_FORM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && st_r == ST_EXEC && exec_done_i |=>
		stat_first_o && stat_byte_o == {1'b0, $past(resp_code_i)})
		else $error("response form first byte wrong");
	AST_DEV_STATUS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && st_r == ST_EXEC && exec_done_i ##1 ce_i && stat_ready_i |=>
		!stat_first_o && stat_valid_o && stat_byte_o == $past(dev_status_i, 2))
		else $error("device status not in second byte");
	AST_TWO_BYTES: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && stat_first_o && stat_ready_i |=> stat_valid_o && !stat_first_o && !hdr_done_o)
		else $error("second status byte missing");
	AST_HDR_DONE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && stat_valid_o && !stat_first_o && stat_ready_i |=> hdr_done_o && !stat_valid_o)
		else $error("header end not marked after two bytes");
	AST_DIP_HELD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		run_r && $past(run_r) |-> $stable(bus_addr_o) && $stable(baud_sel_o) && $stable(lamp_r))
		else $error("switch setting changed after start-up");
	AST_INTERNAL_SEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		ce_i && msg_fire && !rx_fault |=> exec_req_o && internal_sel_o == ($past(msg_slave_i) == 4'h0))
		else $error("internal group select wrong");
endmodule

/* File: rse_exec_model.sv */
`timescale 1ns/10ps
// executor stand-in: answers each execute request after dly_i cycles
module rse_exec_model import rse_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic exec_req_i,
	input wire logic [3:0] dly_i,
	input wire logic [6:0] code_i,
	input wire logic [7:0] stat_i,
	output logic exec_done_o,
	output logic [6:0] resp_code_o,
	output logic [7:0] dev_status_o
);
	// result lines are only valid with done; otherwise show the inverse so stale use shows
	assign resp_code_o = exec_done_o ? code_i : ~code_i;
	assign dev_status_o = exec_done_o ? stat_i : ~stat_i;
	initial exec_done_o = 1'b0;
	// one result pulse per request, prompt (0) or slow
	always @(posedge sys_clk_i) begin
		if (exec_req_i) begin
			repeat (dly_i) @(posedge sys_clk_i);
			exec_done_o <= 1'b1;
			@(posedge sys_clk_i);
			exec_done_o <= 1'b0;
		end
	end
endmodule

/* File: response_status_encoder_tb_top.sv */
`timescale 1ns/10ps
module response_status_encoder_tb_top import rse_pkg::*;;
	logic sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, msg_done, awready, wready;
	logic par, ovr, frm, chk_e, ovf, cpu_f, rom_f, ram_f, exec_req, exec_done, isel, irq;
	logic stat_valid, stat_first, hdr_done, msg_ready, bvalid, arready, rvalid, red, grn, org;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] dip, dstat, sbyte, dev_in;
	logic [6:0] code, rcode;
	logic [3:0] slave, baddr, dly;
	logic [2:0] baud;
	logic [2:0] flt[5] = '{3'b000, 3'b100, 3'b010, 3'b001, 3'b000};
	logic [2:0] ledx[5] = '{3'b010, 3'b111, 3'b100, 3'b110, 3'b110};
	logic ce, srdy;
	logic [2:0] lit;
	logic [6:0] codes[4] = '{7'h00, 7'h08, 7'h1f, 7'h7f};
	int err_total, compares, nreq, i;
	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;
	// count execute pulses to prove faulty messages are dropped
	always @(posedge sys_clk) if (exec_req === 1'b1) nreq++;
	rse_top #(.STARTUP_CYCLES(20), .LAMP_CYCLES(3)) rse_top_i (
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .ce_i(ce), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .dip_i(dip), .msg_done_i(msg_done), .msg_ready_o(msg_ready),
		.msg_slave_i(slave), .par_err_i(par), .ovr_err_i(ovr), .frm_err_i(frm),
		.chk_err_i(chk_e), .buf_ovf_i(ovf), .exec_req_o(exec_req), .internal_sel_o(isel),
		.exec_done_i(exec_done), .resp_code_i(rcode), .dev_status_i(dstat),
		.stat_byte_o(sbyte), .stat_valid_o(stat_valid), .stat_first_o(stat_first),
		.stat_ready_i(srdy), .hdr_done_o(hdr_done), .cpu_fault_i(cpu_f), .rom_fault_i(rom_f),
		.ram_fault_i(ram_f), .bus_addr_o(baddr), .baud_sel_o(baud), .led_red_o(red),
		.led_green_o(grn), .led_orange_o(org), .irq_o(irq));
	rse_exec_model rse_exec_model_i (.sys_clk_i(sys_clk), .exec_req_i(exec_req), .dly_i(dly),
		.code_i(code), .stat_i(dev_in), .exec_done_o(exec_done), .resp_code_o(rcode),
		.dev_status_o(dstat));
	// ----------------------------------------
	// check and closing helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 100) begin
			err_total++;
			stop_test();
		end
	endtask
	// ----------------------------------------
	// bus and message tasks
	// ----------------------------------------
	// lv is written inside the start-up window, where the loop delay is judged
	task automatic rst(input logic [2:0] f, input logic [7:0] lv);
		{cpu_f, rom_f, ram_f} <= f;
		reset_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		wr(OFS_LOOP_DLY, {24'h0, lv}, RESP_OKAY);
		repeat (30) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		tmo(n);
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		tmo(n);
		chk("rdata", ed, rdata);
		chk("rresp", er, rresp);
		// let an edge pass so a following read does not lower and raise rready at once
		@(posedge sys_clk);
	endtask
	// fl is {parity, overrun, framing, checksum, overflow}; h stalls the consumer on byte one
	task automatic msg(input logic [3:0] s, input logic [4:0] fl, input logic [6:0] c,
		input logic h);
		logic [7:0] e0;
		int n, r0;
		e0 = |fl ? {1'b1, fl[4:1], 1'b0, fl[0], 1'b0} : {1'b0, c};
		r0 = nreq;
		for (n = 0; n < 100 && msg_ready !== 1'b1; n++) @(posedge sys_clk);
		tmo(n);
		{msg_done, srdy, slave, par, ovr, frm, chk_e, ovf, code} <= {1'b1, !h, s, fl, c};
		@(posedge sys_clk);
		msg_done <= 1'b0;
		for (n = 0; n < 100 && stat_valid !== 1'b1; n++) @(posedge sys_clk);
		tmo(n);
		chk("byte one", {1'b1, e0}, {stat_first, sbyte});
		if (h) begin
			repeat (3) @(posedge sys_clk);
			chk("byte one held", {2'b11, e0}, {stat_valid, stat_first, sbyte});
			srdy <= 1'b1;
			@(posedge sys_clk);
		end
		@(posedge sys_clk);
		chk("byte two", {2'b10, |fl ? 8'h00 : dev_in}, {stat_valid, stat_first, sbyte});
		chk("exec count", |fl ? 0 : 1, nreq - r0);
		if (!(|fl)) chk("internal", s == 4'h0, isel);
		@(posedge sys_clk);
		chk("hdr done", 1'b1, hdr_done);
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, msg_done, par, ovr, frm, chk_e, ovf} = '0;
		{awaddr, araddr, wdata, slave, code, dev_in, dly} = '0;
		{cpu_f, rom_f, ram_f, reset_n, dip} = {4'h0, 8'hac};
		{ce, srdy} = 2'h3;
		{err_total, compares, nreq} = '0;
		// entry 4 is a loop delay below range written during start-up
		for (i = 4; i >= 0; i--) begin
			rst(flt[i], i == 4 ? 8'h00 : LOOP_DLY_RST);
			chk("leds", ledx[i], {red, grn, org});
			chk("msg ready", i == 0, msg_ready);
		end
		$display("start-up display test done");
		dip <= 8'h53;
		repeat (10) @(posedge sys_clk);
		chk("switches", {4'h6, 3'h5}, {baddr, baud});
		rd(OFS_DEV_STAT, 32'h0456_0000, RESP_OKAY);
		$display("switch capture test done");
		dev_in <= 8'h5a;
		// every fault flag alone, each followed by a resend that executes
		for (i = 0; i < 5; i++) begin
			msg(4'h3, 5'h01 << i, 7'h00, i == 0);
			msg(4'h3, 5'h00, 7'h05, 1'b0);
		end
		$display("fault form test done");
		wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		chk("irq", 1'b1, irq);
		rd(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
		wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		chk("irq", 1'b0, irq);
		rd(OFS_IRQ_STAT, 32'h6, RESP_OKAY);
		rd(OFS_LOOP_DLY, {24'h0, LOOP_DLY_RST}, RESP_OKAY);
		rd(12'h100, 32'h0, RESP_SLVERR);
		wr(12'h100, 32'h1, RESP_SLVERR);
		$display("register test done");
		// warnings and success must not raise the command error bit
		wr(OFS_IRQ_STAT, 32'h6, RESP_OKAY);
		for (i = 0; i < 4; i++) begin
			dly <= i[0] ? 4'h9 : 4'h0;
			msg(i[1] ? 4'h0 : 4'h2, 5'h00, codes[i], i[1]);
			rd(OFS_IRQ_STAT, {29'h0, i == 3, 2'h2}, RESP_OKAY);
		end
		$display("response form test done");
		// lamp test chosen at power-up; a low enable must freeze the sequence
		dip <= 8'h01;
		rst(3'h0, LOOP_DLY_RST);
		lit = 3'h0;
		for (i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			chk("lamp one lit", 1'b1, $onehot({red, grn, org}));
			lit = lit | {red, grn, org};
		end
		chk("lamp all seen", 3'h7, lit);
		ce <= 1'b0;
		@(posedge sys_clk);
		lit = {red, grn, org};
		repeat (5) @(posedge sys_clk);
		chk("frozen leds", lit, {red, grn, org});
		$display("lamp and enable test done");
		stop_test();
	end
endmodule
